//--- rtl/wdm_pkg.sv
// constants shared by the watchdog, supply monitor and reset-flag block
`default_nettype none
package wdm_pkg;
   // register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_WDT_CTRL = 8'h31;
   localparam logic [7:0] IDX_SUPPLY = 8'h30;
   localparam logic [7:0] IDX_RST_FLAGS = 8'h2F;
   localparam logic [7:0] IDX_PROTECT = 8'h3C;
   localparam logic [7:0] IDX_RESTART = 8'h3D;
   localparam logic [9:0] ADDR_WDT_CTRL = {IDX_WDT_CTRL, 2'b00};
   localparam logic [9:0] ADDR_SUPPLY = {IDX_SUPPLY, 2'b00};
   localparam logic [9:0] ADDR_RST_FLAGS = {IDX_RST_FLAGS, 2'b00};
   localparam logic [9:0] ADDR_PROTECT = {IDX_PROTECT, 2'b00};
   localparam logic [9:0] ADDR_RESTART = {IDX_RESTART, 2'b00};

   // watchdog control fields
   localparam int WDT_IRQ_FLAG_BIT = 7;
   localparam int WDT_IRQ_EN_BIT = 6;
   localparam int WDT_PS_HI_BIT = 5;
   localparam int WDT_RST_EN_BIT = 3;
   localparam int WDT_PS_LO_MSB = 2;

   // supply monitor fields
   localparam int SUP_FLAG_BIT = 7;
   localparam int SUP_IRQ_EN_BIT = 6;
   localparam int SUP_LEVEL_MSB = 2;
   localparam logic [2:0] SUP_LEVEL_OFF = 3'h0;
   localparam logic [2:0] SUP_LEVEL_POR_LO = 3'h1;
   localparam logic [2:0] SUP_LEVEL_POR_HI = 3'h2;
   localparam logic [2:0] SUP_LEVEL_FLAG_LO = 3'h3;
   localparam logic [2:0] SUP_LEVEL_FLAG_HI = 3'h4;

   // reset source fields
   localparam int RST_WDT_BIT = 3;
   localparam int RST_PIN_BIT = 1;
   localparam int RST_PWR_BIT = 0;

   // reset values
   localparam logic [3:0] WDT_PS_RESET = 4'h0;
   localparam logic [2:0] SUP_LEVEL_RESET = 3'h0;
   localparam logic PWR_FLAG_RESET = 1'b1;
   localparam logic FUSE_RESET = 1'b1;

   // prescaler: code 0 is 2048 oscillator cycles, code 9 is 1048576
   localparam logic [3:0] WDT_PS_MAX = 4'h9;
   localparam logic [20:0] WDT_BASE_CYCLES = 21'h000800;

   // change protection
   localparam logic [7:0] PROTECT_SIGNATURE = 8'hD8;
   localparam logic [2:0] PROTECT_WINDOW_CYC = 3'h4;
endpackage : wdm_pkg
`default_nettype wire

//--- rtl/wdm_top.sv
// watchdog, supply-level monitor and reset-source flags behind an APB slave
// Operation
// - timeout in interrupt mode sets flag
// - vector execution or writing one clears flag
// - unprogrammed fuse: enable bits choose mode
// - both enables: first timeout interrupts, then reset
// - combined-mode vector clears enable and flag
// - unserviced combined interrupt: next timeout resets
// - programmed fuse forces system reset mode
// - watchdog control bit 4 reads zero
// - watchdog reset flag forces reset enable
// - prescaler selects 2048 to 1048576 cycles
// - supply flag set on trigger, cleared when off or supply not below
// - supply interrupt each time flag sets
// - trigger level codes select off, reset, flag
// - reset flags bits 7:4, 2 read zero
// - watchdog reset flag set, cleared by zero
// - pin reset flag set, cleared by zero
// - power-up flag cleared only by software
// - counter stepped by 128 kHz oscillator
// - protected changes need signature within four cycles
// - restart clears counter; reset pulse one cycle
`timescale 1ns/1ps
`default_nettype none
module wdm_top
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wdt_osc,
   input wire logic safety_lock_fuse,
   input wire logic supply_below,
   input wire logic pin_reset_seen,
   input wire logic wdt_vector_ack,
   output logic wdt_irq,
   output logic supply_irq,
   output logic wdt_reset_pulse,
   output logic supply_por_req
);
   // synchronisers for pin-side inputs
   logic osc_s1_q, osc_s2_q, osc_s3_q;
   logic fuse_s1_q, fuse_q;
   logic below_s1_q, below_q;
   logic pin_s1_q, pin_s2_q, pin_s3_q;

   // register state
   logic to_flag_q, to_ie_q, sre_q;
   logic [3:0] prescale_q;
   logic sup_flag_q, sup_ie_q;
   logic [2:0] sup_level_q;
   logic wdt_cause_q, pin_cause_q, pwr_cause_q;
   logic [2:0] protect_cnt_q;

   // bus answer and outputs
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   logic wdt_irq_q, supply_irq_q, wdt_reset_pulse_q, supply_por_req_q;

   // combinational terms
   logic setup, access, wr;
   logic wr_wdt, wr_sup, wr_rst, wr_prot, wr_restart;
   logic mapped;
   logic osc_tick, pin_event;
   logic window_open;
   logic sre_eff, reset_en, irq_en, run;
   logic timeout, fire_irq, fire_rst, combined;
   logic sre_ok, ps_ok;
   logic [3:0] ps_w;
   logic sup_armed, sup_set, sup_clr;
   logic [31:0] rd_val;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
      end
      else
      begin
         osc_s1_q <= wdt_osc;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fuse_s1_q <= wdm_pkg::FUSE_RESET;
         fuse_q <= wdm_pkg::FUSE_RESET;
         below_s1_q <= 1'b0;
         below_q <= 1'b0;
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end
      else
      begin
         fuse_s1_q <= safety_lock_fuse;
         fuse_q <= fuse_s1_q;
         below_s1_q <= supply_below;
         below_q <= below_s1_q;
         pin_s1_q <= pin_reset_seen;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   // the oscillator is far slower than ref_clk, so each rising edge is one tick
   assign osc_tick = osc_s2_q && !osc_s3_q;
   assign pin_event = pin_s2_q && !pin_s3_q;

   // bus decode: one wait-free access phase, pready raised after setup
   assign setup = psel && !penable;
   assign access = psel && penable && pready_q;
   assign wr = access && pwrite && !pslverr_q;
   assign wr_wdt = wr && (paddr == wdm_pkg::ADDR_WDT_CTRL);
   assign wr_sup = wr && (paddr == wdm_pkg::ADDR_SUPPLY);
   assign wr_rst = wr && (paddr == wdm_pkg::ADDR_RST_FLAGS);
   assign wr_prot = wr && (paddr == wdm_pkg::ADDR_PROTECT);
   assign wr_restart = wr && (paddr == wdm_pkg::ADDR_RESTART);
   assign mapped = (paddr == wdm_pkg::ADDR_WDT_CTRL) || (paddr == wdm_pkg::ADDR_SUPPLY)
      || (paddr == wdm_pkg::ADDR_RST_FLAGS) || (paddr == wdm_pkg::ADDR_PROTECT)
      || (paddr == wdm_pkg::ADDR_RESTART);

   // watchdog mode
   assign sre_eff = sre_q || wdt_cause_q;
   assign reset_en = !fuse_q || sre_eff;
   assign irq_en = fuse_q && to_ie_q;
   assign run = reset_en || irq_en;
   assign combined = reset_en && irq_en;
   // a still-pending flag in combined mode means the handler never ran
   assign fire_irq = timeout && irq_en && !(reset_en && to_flag_q);
   assign fire_rst = timeout && reset_en && (!irq_en || to_flag_q);

   wdm_wdt_count u_count
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .osc_tick(osc_tick),
      .clear(wr_restart || !run || wdt_reset_pulse_q || pin_event),
      .prescale_sel(prescale_q),
      .timeout_q(timeout)
   );

   // protected write window
   assign window_open = (protect_cnt_q != 3'h0);
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         protect_cnt_q <= 3'h0;
      else if (wr_prot && (pwdata[7:0] == wdm_pkg::PROTECT_SIGNATURE))
         protect_cnt_q <= wdm_pkg::PROTECT_WINDOW_CYC;
      else if (wr_wdt)
         protect_cnt_q <= 3'h0;
      else if (window_open)
         protect_cnt_q <= 3'(protect_cnt_q - 3'h1);
   end

   // level 1: enabling is free, disabling needs the window; level 2: timeout needs it
   assign ps_w = {pwdata[wdm_pkg::WDT_PS_HI_BIT], pwdata[wdm_pkg::WDT_PS_LO_MSB:0]};
   assign sre_ok = fuse_q && (pwdata[wdm_pkg::WDT_RST_EN_BIT] || !sre_q || window_open);
   assign ps_ok = fuse_q ? (sre_ok || (ps_w == prescale_q)) : window_open;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         sre_q <= 1'b0;
      else if (wr_wdt && sre_ok)
         sre_q <= pwdata[wdm_pkg::WDT_RST_EN_BIT] || wdt_cause_q;
      else if (wdt_cause_q)
         sre_q <= 1'b1;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         prescale_q <= wdm_pkg::WDT_PS_RESET;
      else if (wr_wdt && ps_ok)
         prescale_q <= ps_w;
   end

   // a software set of the enable wins over the vector clear in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         to_ie_q <= 1'b0;
      else if (wr_wdt)
         to_ie_q <= pwdata[wdm_pkg::WDT_IRQ_EN_BIT];
      else if (wdt_vector_ack && combined)
         to_ie_q <= 1'b0;
   end

   // timeout set wins over a clear arriving in the same cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         to_flag_q <= 1'b0;
      else if (fire_irq)
         to_flag_q <= 1'b1;
      else if (wdt_vector_ack)
         to_flag_q <= 1'b0;
      else if (wr_wdt && pwdata[wdm_pkg::WDT_IRQ_FLAG_BIT])
         to_flag_q <= 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wdt_irq_q <= 1'b0;
         wdt_reset_pulse_q <= 1'b0;
      end
      else
      begin
         wdt_irq_q <= (to_flag_q || fire_irq) && irq_en && !wdt_vector_ack;
         wdt_reset_pulse_q <= fire_rst;
      end
   end

   // supply monitor; codes 101..111 neither set the flag nor request a reset
   assign sup_armed = (sup_level_q == wdm_pkg::SUP_LEVEL_FLAG_LO)
      || (sup_level_q == wdm_pkg::SUP_LEVEL_FLAG_HI);
   assign sup_set = sup_armed && below_q;
   assign sup_clr = (sup_level_q == wdm_pkg::SUP_LEVEL_OFF) || !below_q;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sup_level_q <= wdm_pkg::SUP_LEVEL_RESET;
         sup_ie_q <= 1'b0;
      end
      else if (wr_sup)
      begin
         sup_level_q <= pwdata[wdm_pkg::SUP_LEVEL_MSB:0];
         sup_ie_q <= pwdata[wdm_pkg::SUP_IRQ_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         sup_flag_q <= 1'b0;
      else if (sup_set)
         sup_flag_q <= 1'b1;
      else if (sup_clr)
         sup_flag_q <= 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         supply_irq_q <= 1'b0;
         supply_por_req_q <= 1'b0;
      end
      else
      begin
         supply_irq_q <= sup_set && !sup_flag_q && sup_ie_q;
         supply_por_req_q <= below_q && ((sup_level_q == wdm_pkg::SUP_LEVEL_POR_LO)
            || (sup_level_q == wdm_pkg::SUP_LEVEL_POR_HI));
      end
   end

   // reset sources; rst_n is the power-up reset, set wins over a software clear
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         wdt_cause_q <= 1'b0;
      else if (fire_rst)
         wdt_cause_q <= 1'b1;
      else if (wr_rst && !pwdata[wdm_pkg::RST_WDT_BIT])
         wdt_cause_q <= 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         pin_cause_q <= 1'b0;
      else if (pin_event)
         pin_cause_q <= 1'b1;
      else if (wr_rst && !pwdata[wdm_pkg::RST_PIN_BIT])
         pin_cause_q <= 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         pwr_cause_q <= wdm_pkg::PWR_FLAG_RESET;
      else if (wr_rst && !pwdata[wdm_pkg::RST_PWR_BIT])
         pwr_cause_q <= 1'b0;
   end

   // read mux
   always_comb
   begin
      rd_val = 32'h00000000;
      unique case (paddr)
         wdm_pkg::ADDR_WDT_CTRL:
         begin
            rd_val[wdm_pkg::WDT_IRQ_FLAG_BIT] = to_flag_q;
            rd_val[wdm_pkg::WDT_IRQ_EN_BIT] = to_ie_q;
            rd_val[wdm_pkg::WDT_PS_HI_BIT] = prescale_q[3];
            rd_val[wdm_pkg::WDT_RST_EN_BIT] = sre_eff || !fuse_q;
            rd_val[wdm_pkg::WDT_PS_LO_MSB:0] = prescale_q[2:0];
         end
         wdm_pkg::ADDR_SUPPLY:
         begin
            rd_val[wdm_pkg::SUP_FLAG_BIT] = sup_flag_q;
            rd_val[wdm_pkg::SUP_IRQ_EN_BIT] = sup_ie_q;
            rd_val[wdm_pkg::SUP_LEVEL_MSB:0] = sup_level_q;
         end
         wdm_pkg::ADDR_RST_FLAGS:
         begin
            rd_val[wdm_pkg::RST_WDT_BIT] = wdt_cause_q;
            rd_val[wdm_pkg::RST_PIN_BIT] = pin_cause_q;
            rd_val[wdm_pkg::RST_PWR_BIT] = pwr_cause_q;
         end
         default:
            rd_val = 32'h00000000;
      endcase
   end

   // answer one cycle after setup; read data captured at the setup edge
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end
      else if (setup)
      begin
         pready_q <= 1'b1;
         pslverr_q <= !mapped;
         prdata_q <= pwrite ? 32'h00000000 : rd_val;
      end
      else
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign wdt_irq = wdt_irq_q;
   assign supply_irq = supply_irq_q;
   assign wdt_reset_pulse = wdt_reset_pulse_q;
   assign supply_por_req = supply_por_req_q;
endmodule : wdm_top
`default_nettype wire

//--- rtl/wdm_wdt_count.sv
// watchdog timeout counter stepped by synchronised oscillator ticks
`timescale 1ns/1ps
`default_nettype none
module wdm_wdt_count
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic osc_tick,
   input wire logic clear,
   input wire logic [3:0] prescale_sel,
   output logic timeout_q
);
   logic [19:0] count_q;
   logic [20:0] span;
   logic [19:0] last;
   logic [3:0] code;

   always_comb
   begin
      // reserved codes fall back to the longest defined timeout
      code = (prescale_sel > wdm_pkg::WDT_PS_MAX) ? wdm_pkg::WDT_PS_MAX : prescale_sel;
      span = wdm_pkg::WDT_BASE_CYCLES << code;
      last = 20'(span - 21'h000001);
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         count_q <= 20'h00000;
      else if (clear)
         count_q <= 20'h00000;
      else if (osc_tick)
         count_q <= (count_q == last) ? 20'h00000 : 20'(count_q + 20'h00001);
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         timeout_q <= 1'b0;
      else
         timeout_q <= !clear && osc_tick && (count_q == last);
   end
endmodule : wdm_wdt_count
`default_nettype wire

//--- testbench/wdm_chk.sv
// port assertions for the watchdog, supply monitor and reset flag block
`timescale 1ns/1ps
`default_nettype none
module wdm_chk
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [9:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wdt_osc,
   input wire logic safety_lock_fuse,
   input wire logic supply_below,
   input wire logic pin_reset_seen,
   input wire logic wdt_vector_ack,
   input wire logic wdt_irq,
   input wire logic supply_irq,
   input wire logic wdt_reset_pulse,
   input wire logic supply_por_req
);
   logic [2:0] sb_cnt_q;
   logic [2:0] fuse_cnt_q;
   logic sb_last_q;
   logic rd_ack;
   assign rd_ack = psel && penable && pready && !pwrite && !pslverr;
   // counters give the async inputs room for their synchroniser delay
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sb_last_q <= 1'b0;
         sb_cnt_q <= 3'h0;
         fuse_cnt_q <= 3'h0;
      end
      else
      begin
         sb_last_q <= supply_below;
         if (supply_below != sb_last_q)
            sb_cnt_q <= 3'h0;
         else if (sb_cnt_q != 3'h7)
            sb_cnt_q <= sb_cnt_q + 3'h1;
         if (safety_lock_fuse)
            fuse_cnt_q <= 3'h0;
         else if (fuse_cnt_q != 3'h7)
            fuse_cnt_q <= fuse_cnt_q + 3'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_ctrl_bit4_zero: assert property (
      rd_ack && paddr == wdm_pkg::ADDR_WDT_CTRL |-> !prdata[4])
      else $error("watchdog control bit 4 read as one");
   a_flags_rsvd_zero: assert property (
      rd_ack && paddr == wdm_pkg::ADDR_RST_FLAGS |-> prdata[7:4] == 4'h0 && !prdata[2])
      else $error("reserved reset flag bits read as one");
   a_reset_one_cycle: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
      else $error("watchdog reset pulse too long");
   a_supply_irq_cause: assert property (
      supply_irq |-> supply_below && sb_last_q ##1 !supply_irq)
      else $error("supply interrupt without low supply or too long");
   a_por_follows_low: assert property (
      supply_por_req |-> supply_below || sb_last_q || sb_cnt_q < 3'h4)
      else $error("supply reset request outlives low supply");
   a_ack_clears_irq: assert property (wdt_vector_ack |-> ##2 !wdt_irq)
      else $error("vector ack did not clear watchdog interrupt");
   a_locked_no_irq: assert property (fuse_cnt_q == 3'h7 |-> !wdt_irq)
      else $error("watchdog interrupt while fuse programmed");
   a_locked_rst_en: assert property (
      rd_ack && paddr == wdm_pkg::ADDR_WDT_CTRL && fuse_cnt_q == 3'h7 |-> prdata[3])
      else $error("reset enable reads zero while fuse programmed");
   c_wdt_reset: cover property (wdt_reset_pulse);
   c_supply_irq: cover property (supply_irq);
   c_wdt_irq: cover property ($rose(wdt_irq));
endmodule : wdm_chk
bind wdm_top wdm_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .wdt_osc(wdt_osc), .safety_lock_fuse(safety_lock_fuse),
   .supply_below(supply_below), .pin_reset_seen(pin_reset_seen),
   .wdt_vector_ack(wdt_vector_ack), .wdt_irq(wdt_irq), .supply_irq(supply_irq),
   .wdt_reset_pulse(wdt_reset_pulse), .supply_por_req(supply_por_req));
`default_nettype wire

//--- testbench/wdm_top_tb.sv
// self-checking bench for the watchdog, supply monitor and reset flag block
`timescale 1ns/1ps
`default_nettype none
module wdm_top_tb;
   logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, errv;
   logic [9:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdv;
   logic pready, pslverr, wdt_irq, supply_irq, wdt_reset_pulse, supply_por_req;
   logic wdt_osc = 0, fuse = 1, below = 0, pin = 0, ack = 0;
   logic [1:0] div = '0;
   int num_errors = 0, n_checks = 0, cyc = 0, ticks = 0, t0 = 0;
   always #20 ref_clk = ~ref_clk;
   wdm_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wdt_osc(wdt_osc), .safety_lock_fuse(fuse), .supply_below(below),
      .pin_reset_seen(pin), .wdt_vector_ack(ack), .wdt_irq(wdt_irq),
      .supply_irq(supply_irq), .wdt_reset_pulse(wdt_reset_pulse),
      .supply_por_req(supply_por_req));
   // a tick every fourth clock keeps the longest timeout used near 16384 cycles
   always @(posedge ref_clk)
   begin
      div <= div + 2'h1;
      wdt_osc <= div[1];
      if (div == 2'h2)
         ticks <= ticks + 1;
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         num_errors++;
         end_sim();
      end
   end
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // leaves the bus in the access phase so a second call runs back to back
   task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
   endtask : apb
   task automatic idle;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : idle
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
      idle();
   endtask : wr
   task automatic rd(input string nm, input logic [9:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      idle();
      chk(nm, {24'h0, e}, rdv);
   endtask : rd
   task automatic pwr(input logic [7:0] d);
      apb(1'b1, wdm_pkg::ADDR_PROTECT, {24'h0, wdm_pkg::PROTECT_SIGNATURE});
      wr(wdm_pkg::ADDR_WDT_CTRL, d);
   endtask : pwr
   task automatic rs;
      apb(1'b1, wdm_pkg::ADDR_RESTART, 32'h0);
      t0 = ticks;
      idle();
   endtask : rs
   function automatic logic sig(input int k);
      case (k)
         0: return wdt_irq;
         1: return wdt_reset_pulse;
         2: return supply_irq;
         default: return supply_por_req;
      endcase
   endfunction : sig
   task automatic wt(input string nm, input int k, input int lim);
      int n;
      n = 0;
      while (sig(k) !== 1'b1 && n < lim)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk(nm, 32'h1, {31'h0, sig(k)});
   endtask : wt
   task automatic tk(input int n);
      chk("timeout_ticks", 32'h1, {31'h0, (ticks - t0) inside {[n - 1:n + 3]}});
   endtask : tk
   task automatic ack_vec;
      ack <= 1'b1;
      @(posedge ref_clk);
      ack <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : ack_vec
   task automatic t_regs;
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h00);
      rd("supply", wdm_pkg::ADDR_SUPPLY, 8'h00);
      rd("rst_flags", wdm_pkg::ADDR_RST_FLAGS, 8'h01);
      rd("unmapped", 10'h000, 8'h00);
      chk("pslverr", 32'h1, {31'h0, errv});
      wr(wdm_pkg::ADDR_RST_FLAGS, 8'hFF);
      rd("rst_flags", wdm_pkg::ADDR_RST_FLAGS, 8'h01);
      wr(wdm_pkg::ADDR_RST_FLAGS, 8'h00);
      rd("rst_flags", wdm_pkg::ADDR_RST_FLAGS, 8'h00);
      pin <= 1'b1;
      repeat (4) @(posedge ref_clk);
      pin <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rd("rst_flags", wdm_pkg::ADDR_RST_FLAGS, 8'h02);
      wr(wdm_pkg::ADDR_RST_FLAGS, 8'h00);
      rd("rst_flags", wdm_pkg::ADDR_RST_FLAGS, 8'h00);
   endtask : t_regs
   task automatic t_supply;
      wr(wdm_pkg::ADDR_SUPPLY, 8'h43);
      below <= 1'b1;
      wt("supply_irq", 2, 20);
      rd("supply", wdm_pkg::ADDR_SUPPLY, 8'hC3);
      below <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rd("supply", wdm_pkg::ADDR_SUPPLY, 8'h43);
      wr(wdm_pkg::ADDR_SUPPLY, 8'h44);
      below <= 1'b1;
      wt("supply_irq", 2, 20);
      wr(wdm_pkg::ADDR_SUPPLY, 8'h40);
      rd("supply", wdm_pkg::ADDR_SUPPLY, 8'h40);
      wr(wdm_pkg::ADDR_SUPPLY, 8'h01);
      wt("supply_por", 3, 20);
      rd("supply", wdm_pkg::ADDR_SUPPLY, 8'h01);
      below <= 1'b0;
      wr(wdm_pkg::ADDR_SUPPLY, 8'h02);
      below <= 1'b1;
      wt("supply_por", 3, 20);
      rd("supply", wdm_pkg::ADDR_SUPPLY, 8'h02);
      below <= 1'b0;
      wr(wdm_pkg::ADDR_SUPPLY, 8'h00);
   endtask : t_supply
   task automatic t_irq_mode;
      wr(wdm_pkg::ADDR_WDT_CTRL, 8'h40);
      rs();
      wt("wdt_irq", 0, 9000);
      tk(2048);
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'hC0);
      ack_vec();
      chk("wdt_irq", 32'h0, {31'h0, wdt_irq});
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h40);
      rs();
      wt("wdt_irq", 0, 9000);
      wr(wdm_pkg::ADDR_WDT_CTRL, 8'hC1);
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h41);
      rs();
      wt("wdt_irq", 0, 17000);
      tk(4096);
      wr(wdm_pkg::ADDR_WDT_CTRL, 8'h80);
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h00);
   endtask : t_irq_mode
   task automatic t_combined;
      wr(wdm_pkg::ADDR_WDT_CTRL, 8'h48);
      rs();
      wt("wdt_irq", 0, 9000);
      wt("wdt_reset", 1, 9000);
      rd("rst_flags", wdm_pkg::ADDR_RST_FLAGS, 8'h08);
      ack_vec();
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h08);
      wr(wdm_pkg::ADDR_WDT_CTRL, 8'h48);
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h48);
      rs();
      wt("wdt_irq", 0, 9000);
      ack_vec();
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h08);
      pwr(8'h00);
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h08);
      wr(wdm_pkg::ADDR_RST_FLAGS, 8'h00);
      rd("rst_flags", wdm_pkg::ADDR_RST_FLAGS, 8'h00);
      wr(wdm_pkg::ADDR_WDT_CTRL, 8'h00);
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h08);
      pwr(8'h00);
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h00);
   endtask : t_combined
   task automatic t_fuse;
      fuse <= 1'b0;
      repeat (8) @(posedge ref_clk);
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h08);
      wr(wdm_pkg::ADDR_WDT_CTRL, 8'h10);
      rd("wdt_ctrl", wdm_pkg::ADDR_WDT_CTRL, 8'h08);
      rs();
      wt("wdt_reset", 1, 9000);
   endtask : t_fuse
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      t_regs();
      t_supply();
      t_irq_mode();
      t_combined();
      t_fuse();
      end_sim();
   end
endmodule : wdm_top_tb
`default_nettype wire
